// >>> hw/msfcf_frontend.sv
`timescale 1ns/1ps
// Functional notes
// - Modes 0 and 3, rise sample, fall drive
// - Cycles run falling edge to falling edge
// - Double rate: instruction rising, rest both edges
// - First double-rate address bit on next rise
// - Double-rate read: first bit at fall, every edge
// - Select low frames command, 8-bit instruction first
// - Formats 1-1-1, 1-2-2, 1-4-4, 4-4-4
// - Continuous read omits instruction, reuses old one
// - Configuration bit addr32 picks 24 or 32 bit address
// - Instruction picks lane width of later phases
// - All-quad-wide: every phase four lanes
// - Lane zero least significant within group
// - Mode bits enter or leave continuous read
// - Latency cycles, then data at falling edge
// - Read data streams until select rises
// - Non-read command (write or no-data) needs multiple of eight bits
// - Most significant first, byte address increments
// - Busy: array reads ignored, small subset accepted
// - Write data sampled after address, rising edges
// - Status read reports busy and failure
// - Select high: inputs ignored, lanes released
module msfcf_frontend #(
  parameter logic [7:0] OP_READ = 8'h03,
  parameter logic [7:0] OP_FAST = 8'h0B,
  parameter logic [7:0] OP_DUAL = 8'hBB,
  parameter logic [7:0] OP_QUAD = 8'hEB,
  parameter logic [7:0] OP_DDRQ = 8'hED,
  parameter logic [7:0] OP_PROG = 8'h02,
  parameter logic [7:0] OP_STAT = 8'h05,
  parameter logic [7:0] MODE_ENTER = 8'hA0
) (
  input wire logic REF_CLK, // Core clock
  input wire logic RST_N, // Asynchronous reset
  input wire logic SCK, // Serial clock from host
  input wire logic CS_N, // Select from host
  input wire logic [3:0] LANE_IN, // Lane input levels
  output logic [3:0] LANE_OUT, // Lane output levels
  output logic [3:0] LANE_OE_N, // Lane drive enables
  input wire msfcf_pkg::msfcf_cfg_type CFG, // Static configuration
  input wire logic BUSY, // Internal operation running
  input wire logic OP_FAIL, // Last operation failed
  output logic CMD_VALID, // Command accepted pulse
  output logic CMD_REJECT, // Command discarded pulse
  output msfcf_pkg::msfcf_cmd_type CMD, // Command fields
  output logic RD_REQ, // Array read strobe
  output logic [31:0] RD_ADDR, // Array read address
  input wire logic [7:0] RD_DATA, // Array byte, next cycle
  output logic WR_VALID, // Write byte pulse
  output logic [7:0] WR_DATA // Write byte
);

  // ****************************************************************
  // Decoding helpers
  // ****************************************************************
  function automatic msfcf_pkg::msfcf_dec_type decode(input logic [7:0] op, input logic all_quad);
    msfcf_pkg::msfcf_dec_type d;
    d = '0;
    d.lw = msfcf_pkg::LW_ONE;
    case (op)
      OP_READ: begin
        d.has_addr = 1'b1;
        d.is_read = 1'b1;
        d.is_array = 1'b1;
      end
      OP_FAST: begin
        d.has_addr = 1'b1;
        d.has_lat = 1'b1;
        d.is_read = 1'b1;
        d.is_array = 1'b1;
      end
      OP_DUAL, OP_QUAD, OP_DDRQ: begin
        d.lw = (op == OP_DUAL) ? msfcf_pkg::LW_TWO : msfcf_pkg::LW_FOUR;
        d.ddr = (op == OP_DDRQ);
        d.has_addr = 1'b1;
        d.has_mode = 1'b1;
        d.has_lat = 1'b1;
        d.is_read = 1'b1;
        d.is_array = 1'b1;
      end
      OP_PROG: begin
        d.has_addr = 1'b1;
        d.is_write = 1'b1;
      end
      OP_STAT: begin
        d.is_read = 1'b1;
      end
      default: begin
        d.is_read = 1'b0;
      end
    endcase
    if (all_quad) begin
      d.lw = msfcf_pkg::LW_FOUR;
    end
    return d;
  endfunction

  function automatic logic [3:0] group_of(input logic [3:0] lanes, input logic [1:0] lw);
    case (lw)
      msfcf_pkg::LW_ONE: group_of = {3'b000, lanes[0]};
      msfcf_pkg::LW_TWO: group_of = {2'b00, lanes[1:0]};
      default: group_of = lanes;
    endcase
  endfunction

  function automatic logic [3:0] bits_of(input logic [1:0] lw);
    bits_of = 4'h1 << lw;
  endfunction

  // ****************************************************************
  // Link-side signals
  // ****************************************************************
  logic armed_reg;
  logic frame_clr;
  msfcf_pkg::msfcf_phase_type phase_reg;
  msfcf_pkg::msfcf_dec_type dec_reg, dec_cur, dec_new, cont_dec;
  logic [3:0] ins_cnt_reg, lat_reg, wbit_reg, left_reg;
  logic [5:0] grp_cnt_reg;
  logic [msfcf_pkg::SHIFT_WIDTH-1:0] shf_reg, shf_next;
  logic pend_reg, drive_reg, started_reg;
  logic [3:0] neg_smp_reg;
  logic [8:0] lsync1_reg, lsync2_reg, lsync3_reg, lval_reg;
  msfcf_pkg::msfcf_cfg_type cfg_s;
  logic busy_s, fail_s;
  logic [7:0] instr_hold_reg, cont_instr_reg, mode_hold_reg, wr_byte_reg, instr_next;
  logic [31:0] addr_hold_reg;
  logic cont_q_reg, fetch_tgl_reg, wr_tgl_reg, frame_tgl_reg, rd_tgl_reg;
  logic [2:0] mod8_reg;
  logic oe_reg;
  logic [7:0] osh_reg;
  logic [3:0] first_reg, second_reg;

  assign frame_clr = CS_N | ~RST_N | ~armed_reg;

  // Arming needs a select fall after reset
  always_ff @(negedge CS_N or negedge RST_N) begin
    if (!RST_N) begin
      armed_reg <= 1'b0;
    end else begin
      armed_reg <= 1'b1;
    end
  end

  // Configuration and status levels into the serial clock domain
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      lsync1_reg <= msfcf_pkg::LINK_SYNC_RESET;
      lsync2_reg <= msfcf_pkg::LINK_SYNC_RESET;
      lsync3_reg <= msfcf_pkg::LINK_SYNC_RESET;
      lval_reg <= msfcf_pkg::LINK_SYNC_RESET;
    end else begin
      lsync1_reg <= {1'b0, OP_FAIL, BUSY, CFG};
      lsync2_reg <= lsync1_reg;
      lsync3_reg <= lsync2_reg;
      lval_reg <= (lsync2_reg & lsync3_reg) | (lval_reg & (lsync2_reg | lsync3_reg));
    end
  end
  assign cfg_s = lval_reg[5:0];
  assign busy_s = lval_reg[6];
  assign fail_s = lval_reg[7];

  // ****************************************************************
  // Link receive datapath
  // ****************************************************************
  logic skip_instr, in_addr, instr_ev, addr_ev, fetch_ev, wbyte_ev, extra;
  logic [1:0] n_new;
  logic [3:0] gbits, lat_first, bits_now;
  logic [5:0] cnt_next, need;
  logic [msfcf_pkg::SHIFT_WIDTH-1:0] tail;
  logic [31:0] addr_val;
  logic [7:0] mode_val;

  assign cont_dec = decode(cont_instr_reg, cfg_s.quad_wide);
  assign skip_instr = (phase_reg == msfcf_pkg::PH_INSTR) && !started_reg && cont_q_reg;
  assign dec_cur = skip_instr ? cont_dec : dec_reg;
  assign in_addr = (phase_reg == msfcf_pkg::PH_ADDR) || skip_instr;
  assign instr_next = cfg_s.quad_wide ? {shf_reg[3:0], LANE_IN} : {shf_reg[6:0], LANE_IN[0]};
  assign dec_new = decode(instr_next, cfg_s.quad_wide);
  assign instr_ev = (phase_reg == msfcf_pkg::PH_INSTR) && !skip_instr &&
    (ins_cnt_reg + 4'h1 == (cfg_s.quad_wide ? msfcf_pkg::INSTR_NIBBLES : msfcf_pkg::INSTR_BITS));

  always_comb begin
    gbits = bits_of(dec_cur.lw);
    n_new = (dec_cur.ddr && !pend_reg) ? 2'h2 : 2'h1;
    shf_next = shf_reg;
    if (n_new == 2'h2) begin
      shf_next = (shf_next << gbits) | {40'h00_0000_0000, group_of(neg_smp_reg, dec_cur.lw)};
    end
    shf_next = (shf_next << gbits) | {40'h00_0000_0000, group_of(LANE_IN, dec_cur.lw)};
    cnt_next = grp_cnt_reg + {4'h0, n_new};
    need = ((cfg_s.addr32 ? msfcf_pkg::ADDR_BITS_LONG : msfcf_pkg::ADDR_BITS_SHORT) >> dec_cur.lw)
      + (dec_cur.has_mode ? (msfcf_pkg::MODE_BITS >> dec_cur.lw) : 6'h00);
    addr_ev = in_addr && (cnt_next >= need);
    extra = (cnt_next != need);
    tail = extra ? (shf_next >> gbits) : shf_next;
    mode_val = dec_cur.has_mode ? tail[7:0] : 8'h00;
    addr_val = dec_cur.has_mode ? tail[39:8] : tail[31:0];
    if (!cfg_s.addr32) begin
      addr_val = {8'h00, addr_val[23:0]};
    end
    lat_first = (dec_cur.has_lat && (cfg_s.latency > {3'h0, dec_cur.ddr})) ?
      cfg_s.latency - {3'h0, dec_cur.ddr} : 4'h0;
    fetch_ev = addr_ev && dec_cur.is_array && !busy_s;
    wbyte_ev = (phase_reg == msfcf_pkg::PH_WRITE) && (wbit_reg + gbits == msfcf_pkg::BYTE_BITS);
    bits_now = ((phase_reg == msfcf_pkg::PH_INSTR) && !skip_instr) ?
      (cfg_s.quad_wide ? 4'h4 : 4'h1) : (gbits << (n_new - 2'h1));
  end

  // Frame state, cleared while select is high
  always_ff @(posedge SCK or posedge frame_clr) begin
    if (frame_clr) begin
      phase_reg <= msfcf_pkg::PH_INSTR;
      dec_reg <= '0;
      ins_cnt_reg <= 4'h0;
      grp_cnt_reg <= 6'h00;
      lat_reg <= 4'h0;
      wbit_reg <= 4'h0;
      shf_reg <= '0;
      pend_reg <= 1'b0;
      drive_reg <= 1'b0;
      started_reg <= 1'b0;
    end else begin
      started_reg <= 1'b1;
      if (in_addr) begin
        shf_reg <= shf_next;
        grp_cnt_reg <= cnt_next;
        pend_reg <= 1'b0;
        dec_reg <= dec_cur;
        if (addr_ev) begin
          if (dec_cur.is_array && busy_s) begin
            phase_reg <= msfcf_pkg::PH_DROP;
          end else if (dec_cur.is_write) begin
            phase_reg <= msfcf_pkg::PH_WRITE;
          end else if (lat_first == 4'h0) begin
            drive_reg <= 1'b1;
            phase_reg <= msfcf_pkg::PH_READ;
          end else begin
            lat_reg <= lat_first;
            phase_reg <= msfcf_pkg::PH_LAT;
          end
        end else begin
          phase_reg <= msfcf_pkg::PH_ADDR;
        end
      end else begin
        unique case (phase_reg)
          msfcf_pkg::PH_INSTR: begin
            shf_reg <= {40'h00_0000_0000, instr_next[3:0]};
            shf_reg[7:0] <= instr_next;
            ins_cnt_reg <= ins_cnt_reg + 4'h1;
            if (instr_ev) begin
              dec_reg <= dec_new;
              pend_reg <= dec_new.ddr;
              if (dec_new.has_addr) begin
                phase_reg <= msfcf_pkg::PH_ADDR;
              end else if (dec_new.is_read) begin
                drive_reg <= 1'b1;
                phase_reg <= msfcf_pkg::PH_READ;
              end else begin
                phase_reg <= msfcf_pkg::PH_DROP;
              end
            end
          end
          msfcf_pkg::PH_LAT: begin
            lat_reg <= lat_reg - 4'h1;
            if (lat_reg == 4'h1) begin
              drive_reg <= 1'b1;
              phase_reg <= msfcf_pkg::PH_READ;
            end
          end
          msfcf_pkg::PH_WRITE: begin
            shf_reg <= shf_next;
            wbit_reg <= wbyte_ev ? 4'h0 : wbit_reg + gbits;
          end
          msfcf_pkg::PH_ADDR, msfcf_pkg::PH_READ, msfcf_pkg::PH_DROP: begin
            grp_cnt_reg <= grp_cnt_reg;
          end
        endcase
      end
    end
  end

  // Command fields that must outlive the frame
  always_ff @(posedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      instr_hold_reg <= 8'h00;
      cont_instr_reg <= 8'h00;
      addr_hold_reg <= 32'h0000_0000;
      mode_hold_reg <= 8'h00;
      cont_q_reg <= 1'b0;
      mod8_reg <= 3'h0;
      fetch_tgl_reg <= 1'b0;
      wr_tgl_reg <= 1'b0;
      wr_byte_reg <= 8'h00;
      frame_tgl_reg <= 1'b0;
    end else if (!frame_clr) begin
      mod8_reg <= (started_reg ? mod8_reg : 3'h0) + bits_now[2:0];
      if (!started_reg) begin
        frame_tgl_reg <= ~frame_tgl_reg;
      end
      if (instr_ev) begin
        instr_hold_reg <= instr_next;
      end
      if (skip_instr) begin
        instr_hold_reg <= cont_instr_reg;
      end
      if (addr_ev) begin
        addr_hold_reg <= addr_val;
        mode_hold_reg <= mode_val;
        if (dec_cur.has_mode) begin
          cont_q_reg <= (mode_val == MODE_ENTER);
          cont_instr_reg <= skip_instr ? cont_instr_reg : instr_hold_reg;
        end
      end
      if (fetch_ev) begin
        fetch_tgl_reg <= ~fetch_tgl_reg;
      end
      if (wbyte_ev) begin
        wr_byte_reg <= shf_next[7:0];
        wr_tgl_reg <= ~wr_tgl_reg;
      end
    end
  end

  // ****************************************************************
  // Link transmit datapath
  // ****************************************************************
  logic [7:0] rd_byte_reg, byte_src, src, osh_next;
  logic [3:0] obits, cons, left_next, first_g, second_g, oe_mask, show;
  logic is_stat, rd_take;

  always_comb begin
    is_stat = !dec_reg.is_array;
    byte_src = is_stat ? {6'h00, fail_s, busy_s} : rd_byte_reg;
    src = (left_reg == 4'h0) ? byte_src : osh_reg;
    obits = bits_of(dec_reg.lw);
    cons = obits << dec_reg.ddr;
    first_g = 4'(src >> (msfcf_pkg::BYTE_BITS - obits));
    second_g = 4'((src << obits) >> (msfcf_pkg::BYTE_BITS - obits));
    osh_next = src << cons;
    left_next = ((left_reg == 4'h0) ? msfcf_pkg::BYTE_BITS : left_reg) - cons;
    rd_take = drive_reg && (left_reg == 4'h0) && !is_stat;
  end

  always_ff @(negedge SCK or posedge frame_clr) begin
    if (frame_clr) begin
      neg_smp_reg <= 4'h0;
      oe_reg <= 1'b0;
      osh_reg <= 8'h00;
      left_reg <= 4'h0;
      first_reg <= 4'h0;
      second_reg <= 4'h0;
    end else begin
      neg_smp_reg <= LANE_IN;
      if (drive_reg) begin
        oe_reg <= 1'b1;
        osh_reg <= osh_next;
        left_reg <= left_next;
        first_reg <= first_g;
        second_reg <= second_g;
      end
    end
  end

  always_ff @(negedge SCK or negedge RST_N) begin
    if (!RST_N) begin
      rd_tgl_reg <= 1'b0;
    end else if (!frame_clr && rd_take) begin
      rd_tgl_reg <= ~rd_tgl_reg;
    end
  end

  // Double rate shows the second group while the clock is high
  always_comb begin
    show = (dec_reg.ddr && SCK) ? second_reg : first_reg;
    if (dec_reg.lw == msfcf_pkg::LW_ONE) begin
      LANE_OUT = {2'b00, show[0], 1'b0};
      oe_mask = msfcf_pkg::OE_SINGLE;
    end else begin
      LANE_OUT = show;
      oe_mask = (dec_reg.lw == msfcf_pkg::LW_TWO) ? msfcf_pkg::OE_DUAL : msfcf_pkg::OE_QUAD;
    end
    LANE_OE_N = (oe_reg && !frame_clr) ? ~oe_mask : msfcf_pkg::LANES_RELEASED;
  end

  // ****************************************************************
  // Core side
  // ****************************************************************
  logic [4:0] csync1_reg, csync2_reg, csync3_reg, cval_reg, cprev_reg;
  logic last_frame_reg, rd_wait_reg, cs_rise, new_frame, len_ok;
  msfcf_pkg::msfcf_dec_type dec_core;

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      csync1_reg <= msfcf_pkg::CORE_SYNC_RESET;
      csync2_reg <= msfcf_pkg::CORE_SYNC_RESET;
      csync3_reg <= msfcf_pkg::CORE_SYNC_RESET;
      cval_reg <= msfcf_pkg::CORE_SYNC_RESET;
      cprev_reg <= msfcf_pkg::CORE_SYNC_RESET;
    end else begin
      csync1_reg <= {CS_N, frame_tgl_reg, fetch_tgl_reg, rd_tgl_reg, wr_tgl_reg};
      csync2_reg <= csync1_reg;
      csync3_reg <= csync2_reg;
      cval_reg <= (csync2_reg & csync3_reg) | (cval_reg & (csync2_reg | csync3_reg));
      cprev_reg <= cval_reg;
    end
  end

  assign cs_rise = cval_reg[4] & ~cprev_reg[4];
  assign new_frame = cs_rise && (cval_reg[3] != last_frame_reg);
  assign dec_core = decode(instr_hold_reg, CFG.quad_wide);
  assign len_ok = (mod8_reg == 3'h0);

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      last_frame_reg <= 1'b0;
      CMD_VALID <= 1'b0;
      CMD_REJECT <= 1'b0;
      CMD <= '0;
    end else begin
      CMD_VALID <= 1'b0;
      CMD_REJECT <= 1'b0;
      if (new_frame) begin
        last_frame_reg <= cval_reg[3];
        CMD <= {instr_hold_reg, addr_hold_reg, mode_hold_reg, dec_core.is_read, len_ok};
        if (!dec_core.is_read && !len_ok) begin
          CMD_REJECT <= 1'b1;
        end else if (!BUSY || instr_hold_reg == OP_STAT) begin
          CMD_VALID <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      RD_REQ <= 1'b0;
      RD_ADDR <= 32'h0000_0000;
      rd_wait_reg <= 1'b0;
      rd_byte_reg <= 8'h00;
    end else begin
      RD_REQ <= 1'b0;
      rd_wait_reg <= RD_REQ;
      if (rd_wait_reg) begin
        rd_byte_reg <= RD_DATA;
      end
      if (cval_reg[2] != cprev_reg[2]) begin
        RD_ADDR <= addr_hold_reg;
        RD_REQ <= 1'b1;
      end else if (cval_reg[1] != cprev_reg[1]) begin
        RD_ADDR <= RD_ADDR + 32'h0000_0001;
        RD_REQ <= 1'b1;
      end
    end
  end

  always_ff @(posedge REF_CLK or negedge RST_N) begin
    if (!RST_N) begin
      WR_VALID <= 1'b0;
      WR_DATA <= 8'h00;
    end else begin
      WR_VALID <= (cval_reg[0] != cprev_reg[0]);
      if (cval_reg[0] != cprev_reg[0]) begin
        WR_DATA <= wr_byte_reg;
      end
    end
  end

  // ****************************************************************
  // Assertions
  // ****************************************************************
  sequence s_lat_two;
    phase_reg == msfcf_pkg::PH_LAT && lat_reg == 4'h2;
  endsequence
  sequence s_lat_end;
    phase_reg == msfcf_pkg::PH_LAT && lat_reg == 4'h1 ##1 phase_reg == msfcf_pkg::PH_READ;
  endsequence

  a_lat_countdown: assert property (@(posedge SCK) disable iff (frame_clr)
    s_lat_two |=> s_lat_end) else $error("latency countdown wrong");
  a_drive_only_read: assert property (@(posedge SCK) disable iff (frame_clr)
    oe_reg |-> phase_reg == msfcf_pkg::PH_READ) else $error("lanes driven outside read");
  a_first_drive: assert property (@(negedge SCK) disable iff (frame_clr)
    (drive_reg && !oe_reg) |=> oe_reg) else $error("read data not driven at fall");
  a_instr_eight: assert property (@(posedge SCK) disable iff (frame_clr)
    (phase_reg == msfcf_pkg::PH_INSTR && !cfg_s.quad_wide && !skip_instr && ins_cnt_reg == 4'h7)
    |=> phase_reg != msfcf_pkg::PH_INSTR) else $error("instruction not eight bits");
  a_quad_instr: assert property (@(posedge SCK) disable iff (frame_clr)
    (phase_reg == msfcf_pkg::PH_INSTR && cfg_s.quad_wide && !skip_instr && ins_cnt_reg == 4'h1)
    |=> phase_reg != msfcf_pkg::PH_INSTR) else $error("quad instruction not two nibbles");
  a_cont_skip: assert property (@(posedge SCK) disable iff (frame_clr)
    skip_instr |=> phase_reg != msfcf_pkg::PH_INSTR && instr_hold_reg == $past(cont_instr_reg))
    else $error("continuous read did not skip instruction");
  a_ddr_pend: assert property (@(posedge SCK) disable iff (frame_clr)
    (phase_reg == msfcf_pkg::PH_ADDR && pend_reg) |=> !pend_reg && grp_cnt_reg == 6'h01)
    else $error("first double-rate address group wrong");
  a_idle_release: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CS_N |-> LANE_OE_N == msfcf_pkg::LANES_RELEASED) else $error("lanes driven while deselected");
  a_len_reject: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    CMD_VALID |-> CMD.is_read || CMD.len_ok) else $error("bad length command accepted");
  a_busy_subset: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (new_frame && BUSY && instr_hold_reg != OP_STAT) |=> !CMD_VALID)
    else $error("command accepted while busy");
  a_addr_step: assert property (@(posedge REF_CLK) disable iff (!RST_N)
    (cval_reg[1] != cprev_reg[1] && cval_reg[2] == cprev_reg[2]) |=>
    RD_REQ && RD_ADDR == $past(RD_ADDR) + 32'h0000_0001) else $error("read address not stepped");

endmodule

// >>> pkg/msfcf_pkg.sv
package msfcf_pkg;

  // ****************************************************************
  // Lane widths, bit counts and reset values
  // ****************************************************************
  localparam logic [1:0] LW_ONE = 2'h0;
  localparam logic [1:0] LW_TWO = 2'h1;
  localparam logic [1:0] LW_FOUR = 2'h2;
  localparam logic [3:0] INSTR_BITS = 4'h8;
  localparam logic [3:0] INSTR_NIBBLES = 4'h2;
  localparam logic [5:0] MODE_BITS = 6'h08;
  localparam logic [5:0] ADDR_BITS_SHORT = 6'h18;
  localparam logic [5:0] ADDR_BITS_LONG = 6'h20;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [3:0] OE_SINGLE = 4'h2;
  localparam logic [3:0] OE_DUAL = 4'h3;
  localparam logic [3:0] OE_QUAD = 4'hf;
  localparam logic [3:0] LANES_RELEASED = 4'hf;
  localparam logic [4:0] CORE_SYNC_RESET = 5'h10;
  localparam logic [8:0] LINK_SYNC_RESET = 9'h000;
  localparam int SHIFT_WIDTH = 44;

  // ****************************************************************
  // Types
  // ****************************************************************
  typedef enum logic [2:0] {
    PH_INSTR = 3'b000,
    PH_ADDR = 3'b001,
    PH_LAT = 3'b010,
    PH_READ = 3'b011,
    PH_WRITE = 3'b100,
    PH_DROP = 3'b101
  } msfcf_phase_type;

  typedef struct packed {
    logic [1:0] lw;
    logic ddr;
    logic has_addr;
    logic has_mode;
    logic has_lat;
    logic is_read;
    logic is_write;
    logic is_array;
  } msfcf_dec_type;

  typedef struct packed {
    logic [7:0] instr;
    logic [31:0] addr;
    logic [7:0] mode;
    logic is_read;
    logic len_ok;
  } msfcf_cmd_type;

  typedef struct packed {
    logic quad_wide;
    logic addr32;
    logic [3:0] latency;
  } msfcf_cfg_type;

endpackage

// >>> test/msfcf_frontend_bench.sv
`timescale 1ns/1ps
module msfcf_frontend_bench;
  logic ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic busy = 1'b0;
  logic op_fail = 1'b0;
  logic sck, cs_n, cmd_valid, cmd_reject, rd_req, wr_valid;
  logic [3:0] drv, lane_out, lane_oe_n;
  wire logic [3:0] lane_w;
  logic [31:0] rd_addr, r, a;
  logic [7:0] rd_data = 8'h00;
  logic [7:0] wr_data, wb, last_wr;
  msfcf_pkg::msfcf_cmd_type cmd;
  msfcf_pkg::msfcf_cfg_type cfg = '{1'b0, 1'b0, 4'h4};
  int err_count = 0;
  int comparisons = 0;
  int n_ok = 0;
  int n_rej = 0;
  int seed = 80085;
  always #10 ref_clk = ~ref_clk;
  assign lane_w = (~lane_oe_n & lane_out) | (lane_oe_n & drv);
  msfcf_host_model msfcf_host_model_i (.sck(sck), .cs_n(cs_n), .drv(drv), .lane_w(lane_w));
  msfcf_frontend msfcf_frontend_i (.REF_CLK(ref_clk), .RST_N(rst_n), .SCK(sck), .CS_N(cs_n),
    .LANE_IN(lane_w), .LANE_OUT(lane_out), .LANE_OE_N(lane_oe_n), .CFG(cfg), .BUSY(busy),
    .OP_FAIL(op_fail), .CMD_VALID(cmd_valid), .CMD_REJECT(cmd_reject), .CMD(cmd),
    .RD_REQ(rd_req), .RD_ADDR(rd_addr), .RD_DATA(rd_data), .WR_VALID(wr_valid),
    .WR_DATA(wr_data));
  // ****************************************************************
  // Core side model and helpers
  // ****************************************************************
  function automatic logic [7:0] pat(input logic [31:0] x);
    return x[7:0] ^ 8'h5a;
  endfunction
  always @(negedge ref_clk) begin
    if (rd_req === 1'b1) rd_data <= pat(rd_addr);
  end
  always @(posedge ref_clk) begin
    if (cmd_valid === 1'b1) n_ok++;
    if (cmd_reject === 1'b1) n_rej++;
    if (wr_valid === 1'b1) last_wr = wr_data;
  end
  task automatic x(input int w, input int n, input logic [31:0] v, input logic rd);
    msfcf_host_model_i.xfer(w, n, v, rd, r);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    $display("mismatches=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #200000;
    err_count++;
    tally_and_finish();
  end
  initial begin
    #40 rst_n = 1'b1;
    #33;
    a = 32'($random(seed)) & 32'h00ff_fff0;
    msfcf_host_model_i.open_frame();
    // Fast read: its latency covers the core fetch of the first byte
    x(1, 8, 32'h0b, 1'b0);
    x(1, 24, a, 1'b0);
    x(1, 4, 32'h0, 1'b1);
    x(1, 16, 32'h0, 1'b1);
    chk(r, {16'h0, pat(a), pat(a + 1)});
    chk(lane_oe_n, 4'hd);
    msfcf_host_model_i.close_frame();
    chk(lane_oe_n, 4'hf);
    for (int k = 0; k < 2; k++) begin
      wb = 8'($random(seed));
      msfcf_host_model_i.open_frame();
      x(1, 8, 32'h02, 1'b0);
      x(1, 24, a, 1'b0);
      x(1, 8 + 4 * k, k ? {20'h0, wb, 4'h3} : {24'h0, wb}, 1'b0);
      msfcf_host_model_i.close_frame();
      chk(last_wr, wb);
      chk(n_rej, k);
    end
    @(negedge ref_clk) busy <= 1'b1;
    op_fail <= 1'($random(seed));
    #207;
    msfcf_host_model_i.open_frame();
    x(1, 8, 32'h05, 1'b0);
    x(1, 8, 32'h0, 1'b1);
    chk(r, {30'h0, op_fail, 1'b1});
    msfcf_host_model_i.close_frame();
    msfcf_host_model_i.open_frame();
    x(1, 8, 32'h03, 1'b0);
    x(1, 24, a, 1'b0);
    x(1, 8, 32'h0, 1'b1);
    chk(lane_oe_n, 4'hf);
    msfcf_host_model_i.close_frame();
    @(negedge ref_clk) busy <= 1'b0;
    cfg.addr32 <= 1'b1;
    a = 32'($random(seed)) & 32'hffff_fff0;
    #7;
    msfcf_host_model_i.open_frame();
    x(1, 8, 32'hbb, 1'b0);
    x(2, 16, a, 1'b0);
    x(2, 4, 32'h0, 1'b0);
    x(2, 4, 32'h0, 1'b1);
    x(2, 8, 32'h0, 1'b1);
    chk(r, {16'h0, pat(a), pat(a + 1)});
    chk(lane_oe_n, 4'hc);
    msfcf_host_model_i.close_frame();
    @(negedge ref_clk) cfg.addr32 <= 1'b0;
    for (int k = 0; k < 3; k++) begin
      a = 32'($random(seed)) & 32'h00ff_fff0;
      // Set one frame early: the link sees a change only after a few clocks
      cfg.quad_wide = (k != 0);
      msfcf_host_model_i.open_frame();
      if (k == 0) x(1, 8, 32'heb, 1'b0);
      if (k == 2) x(4, 2, 32'heb, 1'b0);
      x(4, 6, a, 1'b0);
      x(4, 2, k ? 32'h0 : 32'ha0, 1'b0);
      x(4, 4, 32'h0, 1'b1);
      x(4, 4, 32'h0, 1'b1);
      chk(r, {16'h0, pat(a), pat(a + 1)});
      chk(lane_oe_n, 4'h0);
      msfcf_host_model_i.close_frame();
      chk(cmd.instr, 8'heb);
    end
    a = 32'($random(seed)) & 32'h00ff_fff0;
    msfcf_host_model_i.open_frame();
    x(4, 2, 32'hed, 1'b0);
    msfcf_host_model_i.xfer_ddr(8, {a[23:0], 8'h00}, r);
    x(4, 4, 32'h0, 1'b1);
    msfcf_host_model_i.xfer_ddr(2, 32'h0, r);
    chk(r, {24'h0, pat(a)});
    chk(lane_oe_n, 4'h0);
    msfcf_host_model_i.close_frame();
    chk(n_ok, 8);
    tally_and_finish();
  end
endmodule

// >>> test/msfcf_host_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Host controller model, clock mode 0
// ****************************************************************
module msfcf_host_model (
  output logic sck, // Serial clock
  output logic cs_n, // Select
  output logic [3:0] drv, // Host lane levels
  input wire logic [3:0] lane_w // Resolved lane levels
);
  initial begin
    sck = 1'b0;
    cs_n = 1'b1;
    drv = 4'h5;
  end
  // One group per cycle: set while low, taken at the rise
  task automatic xfer(input int w, input int n, input logic [31:0] v, input logic rd,
                      output logic [31:0] r);
    r = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      // Released lanes toggle so a stale level never passes for data
      if (rd) drv = ~drv;
      else drv = 4'((v >> (i * w)) & ((1 << w) - 1));
      #40 sck = 1'b1;
      if (w == 1) r = {r[30:0], lane_w[1]};
      else r = (r << w) | 32'(lane_w & 4'((1 << w) - 1));
      #40 sck = 1'b0;
    end
  endtask
  // Double rate: one group on each edge, changed half-way between edges
  task automatic xfer_ddr(input int n, input logic [31:0] v, output logic [31:0] r);
    r = 32'h0;
    for (int i = n - 1; i >= 0; i--) begin
      #20 drv = 4'(v >> (i * 4));
      #20 r = (r << 4) | 32'(lane_w);
      sck = ~sck;
    end
  endtask
  task automatic open_frame;
    cs_n = 1'b0;
  endtask
  task automatic close_frame;
    #20 cs_n = 1'b1;
    drv = ~drv;
    #200;
  endtask
endmodule
